// [tsr_cfg.svh]
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TSR_OFS_SEL_BASE   12'h000
`define TSR_OFS_PIN_OE     12'h040
`define TSR_OFS_PIN_MAP    12'h044
`define TSR_OFS_LINE_DIR   12'h048
`define TSR_OFS_LINE_OUT   12'h04C
`define TSR_OFS_LINE_IN    12'h050
`define TSR_OFS_PIN_IN     12'h054
`define TSR_OFS_TIMING_IN  12'h058
// ----------------------------------------
// counts, fields and reset values
// ----------------------------------------
`define TSR_NUM_TIMING     13
`define TSR_NUM_PINS       10
`define TSR_NUM_LINES      8
`define TSR_SEL_W          4
`define TSR_LINE_DIR_CNT0  6
`define TSR_LINE_DIR_CNT1  7
`define TSR_SEL_RST        4'hA
`define TSR_OE_RST         10'h000
`define TSR_DIR_RST        8'h00
`define TSR_OUT_RST        8'h00
`endif

// [tsr_pkg.sv]
package tsr_pkg;
  `include "tsr_cfg.svh"
  typedef logic [`TSR_SEL_W-1:0] tsr_sel_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } tsr_apb_req_s;
  typedef enum logic [1:0] {
    TSR_IDLE,
    TSR_ACCESS
  } tsr_apb_e;
endpackage

// [tsr_sel_mux.sv]
`timescale 1ns/1ps
// one routed timing signal: selects among pins and its internal sources
module tsr_sel_mux
  import tsr_pkg::*;
(
  input  wire logic [`TSR_NUM_PINS-1:0] pin_in,
  input  wire logic                     int_src0,
  input  wire logic                     int_src1,
  input  wire tsr_sel_t                 sel,
  output logic                          routed
);
  // --------------------------------------
  // selection
  // --------------------------------------
  // codes 0..9 pick a pin, 10 and 11 internal sources, others low
  wire   is_pin = (sel < 4'hA);
  wire   pin_v  = pin_in[sel];
  assign routed = is_pin ? pin_v : (sel == 4'hA) ? int_src0 : (sel == 4'hB) ? int_src1 : 1'b0;
endmodule

// [tsr_apb_slave.sv]
`timescale 1ns/1ps
// apb handshake: zero-wait, answers in the access phase
module tsr_apb_slave
  import tsr_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              wr_stb,
  output logic              rd_stb,
  output tsr_apb_req_s      req
);
  // --------------------------------------
  // phase tracking
  // --------------------------------------
  tsr_apb_e state;
  tsr_apb_e next_state;
  assign next_state = (psel && !penable) ? TSR_ACCESS : TSR_IDLE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TSR_IDLE;
    end else begin
      state <= next_state;
    end
  end
  assign pready = 1'b1;
  wire   acc    = psel && penable && (state == TSR_ACCESS);
  assign wr_stb = acc && pwrite;
  assign rd_stb = acc && !pwrite;
  assign req    = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
endmodule

// [tsr_router.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - each of thirteen timing signals can come from an external pin.
// - each timing signal may instead come from an internal source.
// - conversion strobe chooses pins, interval terminal count, or counter0 output.
// - every selector sees all ten pins; software picks one.
// - several timing signals may use one pin together.
// - each pin has own output enable; then drives its mapped signal.
// - eight general lines, each set input or output by software.
// - general lines are high impedance after reset.
// - lines six and seven give count direction of counters 0 and 1.
// - direction taps only sense lines, never change them.
module tsr_router
  import tsr_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [`TSR_NUM_TIMING-1:0] int_src_a,
  input  wire logic [`TSR_NUM_TIMING-1:0] int_src_b,
  input  wire logic [`TSR_NUM_TIMING-1:0] timing_out,
  input  wire logic                       sample_interval_terminal_count,
  input  wire logic                       counter0_output,
  output logic      [`TSR_NUM_TIMING-1:0] timing_in,
  input  wire logic [`TSR_NUM_PINS-1:0]   function_pin_i,
  output logic      [`TSR_NUM_PINS-1:0]   function_pin_o,
  output logic      [`TSR_NUM_PINS-1:0]   function_pin_oe,
  input  wire logic [`TSR_NUM_LINES-1:0]  general_line_i,
  output logic      [`TSR_NUM_LINES-1:0]  general_line_o,
  output logic      [`TSR_NUM_LINES-1:0]  general_line_oe,
  output logic                            counter0_up,
  output logic                            counter1_up
);
  // --------------------------------------
  // bus slave
  // --------------------------------------
  logic         wr_stb;
  logic         rd_stb;
  tsr_apb_req_s req;
  tsr_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .req     (req)
  );
  // --------------------------------------
  // decode
  // --------------------------------------
  wire [3:0] sel_idx  = req.paddr[5:2];
  wire [11:0] sel_base = `TSR_OFS_SEL_BASE;
  wire       hit_sel  = (req.paddr[11:6] == sel_base[11:6]) && (sel_idx < 4'hD);
  wire       hit_oe   = (req.paddr == `TSR_OFS_PIN_OE);
  wire       hit_map  = (req.paddr == `TSR_OFS_PIN_MAP);
  wire       hit_dir  = (req.paddr == `TSR_OFS_LINE_DIR);
  wire       hit_out  = (req.paddr == `TSR_OFS_LINE_OUT);
  wire       hit_lin  = (req.paddr == `TSR_OFS_LINE_IN);
  wire       hit_pin  = (req.paddr == `TSR_OFS_PIN_IN);
  wire       hit_tin  = (req.paddr == `TSR_OFS_TIMING_IN);
  wire       hit_any  = hit_sel | hit_oe | hit_map | hit_dir | hit_out | hit_lin | hit_pin | hit_tin;
  wire       ro_hit   = hit_lin | hit_pin | hit_tin;
  // unmapped addresses and writes to status words answer with an error
  assign pslverr = (wr_stb | rd_stb) & (!hit_any | (wr_stb & ro_hit));
  // --------------------------------------
  // configuration registers
  // --------------------------------------
  tsr_sel_t                  sel [`TSR_NUM_TIMING];
  logic [`TSR_NUM_PINS-1:0]  pin_oe;
  logic [3:0]                pin_map [`TSR_NUM_PINS];
  logic [`TSR_NUM_LINES-1:0] line_dir;
  logic [`TSR_NUM_LINES-1:0] line_out;
  genvar g;
  generate
    for (g = 0; g < `TSR_NUM_TIMING; g++) begin : g_sel
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel[g] <= `TSR_SEL_RST;
        end else if (wr_stb && hit_sel && sel_idx == 4'(g)) begin
          sel[g] <= req.pwdata[3:0];
        end
      end
    end
    for (g = 0; g < `TSR_NUM_PINS; g++) begin : g_map
      // pin map word: 4 bits per pin for pins 0..7, pins 8,9 keep their reset map to signals 8,9
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_map[g] <= 4'(g);
        end else if (wr_stb && hit_map) begin
          pin_map[g] <= req.pwdata[(g%8)*4 +: 4] & {4{(g < 8) ? 1'b1 : 1'b0}} | pin_map[g] & {4{(g >= 8) ? 1'b1 : 1'b0}};
        end
      end
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe   <= `TSR_OE_RST;
      line_dir <= `TSR_DIR_RST;
      line_out <= `TSR_OUT_RST;
    end else begin
      if (wr_stb && hit_oe) begin
        pin_oe <= req.pwdata[`TSR_NUM_PINS-1:0];
      end
      if (wr_stb && hit_dir) begin
        line_dir <= req.pwdata[`TSR_NUM_LINES-1:0];
      end
      if (wr_stb && hit_out) begin
        line_out <= req.pwdata[`TSR_NUM_LINES-1:0];
      end
    end
  end
  // --------------------------------------
  // timing signal selection
  // --------------------------------------
  // each selector reads the same pin vector, so sharing a pin is free
  generate
    for (g = 0; g < `TSR_NUM_TIMING; g++) begin : g_mux
      // signal 0 is the conversion strobe with its own internal sources
      wire s0 = (g == 0) ? sample_interval_terminal_count : int_src_a[g];
      wire s1 = (g == 0) ? counter0_output : int_src_b[g];
      tsr_sel_mux u_mux (
        .pin_in   (function_pin_i),
        .int_src0 (s0),
        .int_src1 (s1),
        .sel      (sel[g]),
        .routed   (timing_in[g])
      );
    end
  endgenerate
  // --------------------------------------
  // pin outputs
  // --------------------------------------
  logic [`TSR_NUM_PINS-1:0] next_pin_o;
  generate
    for (g = 0; g < `TSR_NUM_PINS; g++) begin : g_pout
      wire [3:0] m = pin_map[g];
      assign next_pin_o[g] = (m < 4'hD) ? timing_out[m] : 1'b0;
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_pin_o <= `TSR_OE_RST;
    end else begin
      function_pin_o <= next_pin_o;
    end
  end
  assign function_pin_oe = pin_oe;
  // --------------------------------------
  // general lines
  // --------------------------------------
  assign general_line_o  = line_out;
  assign general_line_oe = line_dir;
  // sense only, no effect on the line
  assign counter0_up = general_line_i[`TSR_LINE_DIR_CNT0];
  assign counter1_up = general_line_i[`TSR_LINE_DIR_CNT1];
  // --------------------------------------
  // read data
  // --------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_sel) begin
      next_prdata = {28'h000_0000, sel[sel_idx]};
    end else if (hit_oe) begin
      next_prdata = {22'h00_0000, pin_oe};
    end else if (hit_map) begin
      for (int i = 0; i < 8; i++) begin
        next_prdata[i*4 +: 4] = pin_map[i];
      end
    end else if (hit_dir) begin
      next_prdata = {24'h00_0000, line_dir};
    end else if (hit_out) begin
      next_prdata = {24'h00_0000, line_out};
    end else if (hit_lin) begin
      next_prdata = {24'h00_0000, general_line_i};
    end else if (hit_pin) begin
      next_prdata = {22'h00_0000, function_pin_i};
    end else if (hit_tin) begin
      next_prdata = {19'h0_0000, timing_in};
    end
  end
  // read word is captured in the setup cycle so it stands as a flop output
  // through the zero-wait access; status words are thus one cycle old
  wire rd_setup = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_setup ? next_prdata : 32'h0000_0000;
    end
  end
endmodule

// [tsr_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the router
// ----------------------------------------
module tsr_monitor
  import tsr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [12:0] timing_out,
  input wire logic        sample_interval_terminal_count,
  input wire logic [12:0] timing_in,
  input wire logic [9:0]  function_pin_o,
  input wire logic [9:0]  function_pin_oe,
  input wire logic [7:0]  general_line_i,
  input wire logic [7:0]  general_line_oe,
  input wire logic        counter0_up,
  input wire logic        counter1_up
);
  logic [1:0]  hi_q;
  logic [31:0] pw_q;
  wire         acc    = psel && penable && pwrite;
  wire         wr_oe  = acc && paddr == 12'h040;
  wire         wr_dir = acc && paddr == 12'h048;
  // one cycle of history; pins 8 and 9 have a fixed map
  always_ff @(posedge pclk) begin
    hi_q <= timing_out[9:8];
    pw_q <= pwdata;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_dir_tap_zero: assert property (counter0_up == general_line_i[6])
    else $error("counter0 direction differs from line six");
  chk_dir_tap_one: assert property (counter1_up == general_line_i[7])
    else $error("counter1 direction differs from line seven");
  chk_pin_follow: assert property ($past(presetn) |-> function_pin_o[9:8] == hi_q)
    else $error("fixed pins do not follow their timing signals");
  chk_reset_quiet: assert property ($rose(presetn) |-> !function_pin_oe && !general_line_oe)
    else $error("drivers enabled after reset");
  chk_strobe_default: assert property ($rose(presetn) |->
    timing_in[0] == sample_interval_terminal_count)
    else $error("strobe not on internal source after reset");
  chk_oe_load: assert property (wr_oe |=> function_pin_oe == pw_q[9:0])
    else $error("pin enables not loaded");
  chk_dir_load: assert property (wr_dir |=> general_line_oe == pw_q[7:0])
    else $error("line directions not loaded");
  chk_oe_hold: assert property ($changed(function_pin_oe) |-> $past(wr_oe))
    else $error("pin enables changed without a write");
  chk_dir_hold: assert property ($changed(general_line_oe) |-> $past(wr_dir))
    else $error("line directions changed without a write");
  cov_oe_write: cover property (wr_oe);
  cov_dir_write: cover property (wr_dir);
  cov_refused: cover property (psel && penable && pslverr);
endmodule

bind tsr_router tsr_monitor u_mon (.*);

// [tsr_ext_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// outside circuitry on the connector
// ----------------------------------------
module tsr_ext_model (
  input  wire logic [9:0] function_pin_o,
  input  wire logic [9:0] function_pin_oe,
  input  wire logic [7:0] general_line_o,
  input  wire logic [7:0] general_line_oe,
  input  wire logic [9:0] ext_pin,
  input  wire logic [7:0] ext_line,
  output logic      [9:0] function_pin_i,
  output logic      [7:0] general_line_i
);
  // the device wins where its driver is on
  assign function_pin_i = (function_pin_o & function_pin_oe) | (ext_pin & ~function_pin_oe);
  assign general_line_i = (general_line_o & general_line_oe) | (ext_line & ~general_line_oe);
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------
// router bench
// ----------------------------------------
module tb_top
  import tsr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tc, c0, c0u, c1u;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] isa, isb, tout, tin;
  logic [9:0]  pi, po, poe, xp;
  logic [7:0]  li, lo, loe, xl;
  int          fails, check_count;
  tsr_router DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_src_a(isa), .int_src_b(isb), .timing_out(tout),
    .sample_interval_terminal_count(tc), .counter0_output(c0), .timing_in(tin),
    .function_pin_i(pi), .function_pin_o(po), .function_pin_oe(poe), .general_line_i(li),
    .general_line_o(lo), .general_line_oe(loe), .counter0_up(c0u), .counter1_up(c1u));
  tsr_ext_model ext (.function_pin_o(po), .function_pin_oe(poe), .general_line_o(lo),
    .general_line_oe(loe), .ext_pin(xp), .ext_line(xl), .function_pin_i(pi),
    .general_line_i(li));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  // zero-wait slave, but the wait loop still honours pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(poe, 10'h000);
    chk(loe, 8'h00);
    chk(tin, {isa[12:1], tc});
    apb(0, 12'h004, 0);
    chk(rd, 32'hA);
  endtask
  task t_strobe;
    for (int s = 0; s < 12; s++) begin
      apb(1, 12'h000, s);
      for (int v = 0; v < 2; v++) begin
        @(posedge pclk);
        xp <= v ? 10'h1 << s : ~(10'h1 << s);
        tc <= (s == 10) ? v : !v;
        c0 <= (s == 11) ? v : !v;
        @(negedge pclk);
        chk(tin[0], v);
      end
    end
    $display("strobe test done");
  endtask
  task t_shared;
    for (int n = 1; n < 13; n++) apb(1, 12'(4 * n), 3);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      xp <= v ? 10'h008 : 10'h3F7;
      @(negedge pclk);
      chk(tin[12:1], v ? 12'hFFF : 12'h000);
    end
    for (int n = 1; n < 13; n++) apb(1, 12'(4 * n), 11);
    @(negedge pclk);
    chk(tin[12:1], isb[12:1]);
    apb(0, 12'h058, 0);
    chk(rd, {19'h0, isb[12:1], c0});
    $display("shared test done");
  endtask
  task t_pins;
    @(posedge pclk);
    tout <= 13'h1A5C;
    apb(1, 12'h044, 32'h76C43210);
    apb(1, 12'h040, 32'h3FF);
    @(negedge pclk);
    chk(poe, 10'h3FF);
    chk(po, 10'h27C);
    chk(pi, 10'h27C);
    apb(0, 12'h044, 0);
    chk({err, rd}, 33'h076C43210);
    apb(0, 12'h040, 0);
    chk({err, rd}, 33'h0000003FF);
    apb(0, 12'h054, 0);
    chk(rd, 32'h27C);
    apb(1, 12'h040, 0);
    @(negedge pclk);
    chk(poe, 10'h000);
    chk(pi, xp);
    $display("pin test done");
  endtask
  task t_lines;
    apb(1, 12'h048, 32'hF0);
    apb(1, 12'h04C, 32'hA5);
    apb(0, 12'h050, 0);
    chk(rd, 32'hAC);
    apb(0, 12'h048, 0);
    chk({err, rd}, 33'h0000000F0);
    apb(0, 12'h04C, 0);
    chk(rd, 32'hA5);
    chk({c1u, c0u, loe, lo}, 18'h2F0A5);
    apb(1, 12'h048, 0);
    @(posedge pclk);
    xl <= 8'h40;
    @(negedge pclk);
    chk({c1u, c0u, loe}, 10'h100);
    apb(1, 12'h050, 32'hFF);
    chk(err, 1'b1);
    apb(0, 12'h0FC, 0);
    chk({err, rd}, 33'h100000000);
    $display("line test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tout, c0, xp} = 0;
    {isa, isb, tc, xl, fails, check_count} = {13'h1555, 13'h0AAA, 1'b1, 8'h3C, 64'h0};
    rst;
    t_strobe;
    t_shared;
    t_pins;
    t_lines;
    apb(1, 12'h040, 32'h3FF);
    apb(1, 12'h048, 32'hFF);
    rst;
    $display("second reset test done");
    end_of_test;
  end
  initial begin
    #2000000;
    fails++;
    end_of_test;
  end
endmodule
